// ### rtl/tfb_core.sv
// How it works
// RL1: texture, then fog, then blend, in order
// RL2: texture needs register enable and command flag
// RL3: copy mode: texture colour replaces fragment colour
// RL4: decal: alpha-weighted mix, fragment alpha kept
// RL5: modulate: colours and alphas multiplied
// RL6: ramp decal, modulate, highlight each optional, ordered
// RL7: ramp decal off: texture colour, alphas multiplied
// RL8: ramp modulate scales colour and alpha by diffuse
// RL9: ramp highlight adds specular to colour and alpha
// RL10: fog needs register enable and command flag
// RL11: fog test drops negative fog fragments
// RL12: fog interpolator: start, edge step, span step
// RL13: fog index is 18-bit 2.16 two's complement
// RL14: fog index clamped to 0.0..1.0 before use
// RL15: fog mixes RGB with fog colour, alpha kept
// RL16: destination pixel unpacked per layout fields
// RL17: dest alpha one bit forces destination alpha 1.0
// RL18: blend: src times alpha plus dst remainder
// RL19: pre-multiplied: src plus dst remainder
// RL20: format op only reformats destination data
// RL21: narrow components scaled, or shifted when selected
// RL22: intensity interpolators use 2.16 fixed point
// RL23: software enables interpolators for ramp modulate/highlight
// RL24: one fragment per clock, in order, rejects vanish
// RL25: 8-bit components, saturating adds, FF is unity
`timescale 1ns/1ps
`default_nettype none
module tfb_core (
  input wire logic CLOCK, // 40 MHz core clock
  input wire logic RST_N, // asynchronous reset, active low
  input wire logic [7:0] AWADDR, // write address
  input wire logic AWVALID, // write address valid
  output logic AWREADY, // write address ready
  input wire logic [31:0] WDATA, // write data
  input wire logic [3:0] WSTRB, // write byte enables
  input wire logic WVALID, // write data valid
  output logic WREADY, // write data ready
  output logic [1:0] BRESP, // write response
  output logic BVALID, // write response valid
  input wire logic BREADY, // write response ready
  input wire logic [7:0] ARADDR, // read address
  input wire logic ARVALID, // read address valid
  output logic ARREADY, // read address ready
  output logic [31:0] RDATA, // read data
  output logic [1:0] RRESP, // read response
  output logic RVALID, // read data valid
  input wire logic RREADY, // read data ready
  input wire logic FRAG_VALID, // fragment offered
  output logic FRAG_READY, // fragment can be taken
  input wire tfb_pkg::tfb_frag_t FRAG_IN, // fragment payload
  output logic OUT_VALID, // result offered
  input wire logic OUT_READY, // result taken downstream
  output tfb_pkg::tfb_rgba_t OUT_COLOR // result colour
);
  import tfb_pkg::*;

  // -------
  // colour arithmetic
  // -------
  // product with FF as unity, rounded
  function automatic logic [7:0] mul8(input logic [7:0] x, input logic [7:0] y);
    logic [15:0] p;
    logic [15:0] s;
    p = x * y;
    s = p + 16'h0080 + (p >> 8);
    return s[15:8]; // [RL25]
  endfunction : mul8

  // saturating sum
  function automatic logic [7:0] add8(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    s = {1'b0, x} + {1'b0, y};
    return s[8] ? UNITY : s[7:0]; // [RL25]
  endfunction : add8

  // x*k + y*(1-k)
  function automatic logic [7:0] mix8(input logic [7:0] x, input logic [7:0] y,
                                      input logic [7:0] k);
    return add8(mul8(x, k), mul8(y, ~k));
  endfunction : mix8

  // 2.16 value clamped to 0.0..1.0 as an 8-bit weight
  function automatic logic [7:0] unit8(input logic [FIX_W-1:0] v);
    logic [7:0] r;
    if (v[FIX_W-1]) begin
      r = 8'h00;
    end else if (v[FIX_W-2]) begin
      r = UNITY;
    end else begin
      r = v[15:8];
    end
    return r; // [RL14]
  endfunction : unit8

  // widen a w-bit field held in the low bits of v
  function automatic logic [7:0] expand(input logic [7:0] v, input int w,
                                        input logic shift);
    logic [7:0] top;
    logic [7:0] r;
    top = v << (8 - w);
    r = top;
    if (!shift) begin
      for (int i = 1; i < 8; i++) begin
        if (i * w < 8) begin
          r = r | (top >> (i * w)); // [RL21]
        end
      end
    end
    return r;
  endfunction : expand

  // register decode, shared by read and write
  function automatic logic reg_hit(input logic [7:0] addr);
    return (addr[1:0] == 2'b00) && (addr <= A_STATUS);
  endfunction : reg_hit

  // writable bits of each register
  function automatic logic [31:0] reg_mask(input logic [3:0] idx);
    logic [31:0] m;
    unique case (idx)
      4'h0: m = M_TEX;
      4'h1: m = M_FOG;
      4'h2: m = M_WORD;
      4'hC: m = M_BLEND;
      4'hD: m = 32'h0000_0000;
      default: m = M_FIX;
    endcase
    return m;
  endfunction : reg_mask

  // -------
  // register file
  // -------
  logic [31:0] cfg [NUM_REGS];
  logic [15:0] out_count;
  logic [15:0] rej_count;
  logic aw_got;
  logic w_got;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic do_write;
  logic [3:0] wr_idx;
  logic [31:0] wr_mask;
  logic [31:0] strb_bits;

  assign do_write = aw_got && w_got && !BVALID;
  assign wr_idx = wr_addr[5:2];
  assign wr_mask = reg_mask(wr_idx);
  assign strb_bits = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}},
                      {8{wr_strb[0]}}};

  // write channels, address and data in either order
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_got <= 1'b1;
        AWREADY <= 1'b0;
        wr_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_got <= 1'b1;
        WREADY <= 1'b0;
        wr_data <= WDATA;
        wr_strb <= WSTRB;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= reg_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  // stored fields; status bits are read-only
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg[i] <= RST_VAL;
      end
    end else if (do_write && reg_hit(wr_addr)) begin
      cfg[wr_idx] <= (cfg[wr_idx] & ~(wr_mask & strb_bits))
                     | (wr_data & wr_mask & strb_bits);
    end
  end

  // read channel, answer one cycle after the address
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RRESP <= reg_hit(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      if (!reg_hit(ARADDR)) begin
        RDATA <= 32'h0000_0000;
      end else if (ARADDR == A_STATUS) begin
        RDATA <= {rej_count, out_count};
      end else begin
        RDATA <= cfg[ARADDR[5:2]] & reg_mask(ARADDR[5:2]);
      end
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // -------
  // interpolators: fog, specular, diffuse
  // -------
  logic [31:0] tex_ctrl;
  logic [31:0] fog_ctrl;
  logic [31:0] blend_ctrl;
  logic [FIX_W-1:0] dda_cur [3];
  logic [FIX_W-1:0] dda_edge [3];
  logic [FIX_W-1:0] dda_val [3];
  logic [FIX_W-1:0] next_edge [3];
  logic take;

  assign tex_ctrl = cfg[A_TEX_CTRL[5:2]];
  assign fog_ctrl = cfg[A_FOG_CTRL[5:2]];
  assign blend_ctrl = cfg[A_BLEND_CTRL[5:2]];
  assign take = FRAG_VALID && FRAG_READY;

  // start on a new primitive, edge step per row, span step per pixel except on lines
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_edge[i] = dda_edge[i];
      dda_val[i] = dda_cur[i];
      if (FRAG_IN.prim_first) begin
        next_edge[i] = cfg[3 + 3 * i][FIX_W-1:0]; // [RL12] [RL22]
        dda_val[i] = next_edge[i];
      end else if (FRAG_IN.row_first) begin
        next_edge[i] = dda_edge[i] + cfg[5 + 3 * i][FIX_W-1:0]; // [RL12]
        dda_val[i] = next_edge[i];
      end else if (!FRAG_IN.is_line) begin
        dda_val[i] = dda_cur[i] + cfg[4 + 3 * i][FIX_W-1:0]; // [RL12] [RL13]
      end
    end
  end

  // interpolators advance on every taken fragment, kept or not
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 3; i++) begin
        dda_cur[i] <= '0;
        dda_edge[i] <= '0;
      end
    end else if (take) begin
      for (int i = 0; i < 3; i++) begin
        dda_cur[i] <= dda_val[i];
        dda_edge[i] <= next_edge[i];
      end
    end
  end

  // -------
  // colour chain
  // -------
  tfb_rgba_t tex_c;
  tfb_rgba_t fog_c;
  tfb_rgba_t dst_c;
  tfb_rgba_t result;
  tfb_rgb_mode_t rgb_mode;
  tfb_blend_op_t blend_op;
  logic [7:0] kd;
  logic [7:0] ks;
  logic [7:0] f;
  logic reject;
  logic keep;

  // intensities read as zero while their interpolator is off
  assign kd = tex_ctrl[DIFF_EN] ? unit8(dda_val[2]) : 8'h00; // [RL23]
  assign ks = tex_ctrl[SPEC_EN] ? unit8(dda_val[1]) : 8'h00; // [RL23]
  assign f = unit8(dda_val[0]); // [RL14]
  assign rgb_mode = tfb_rgb_mode_t'(tex_ctrl[TEX_MODE +: 2]);
  assign blend_op = tfb_blend_op_t'(blend_ctrl[BL_OP +: 2]);

  // texture stage, first in the chain
  always_comb begin
    tex_c = FRAG_IN.color;
    if (tex_ctrl[TEX_EN] && FRAG_IN.tex_apply) begin // [RL2]
      if (tex_ctrl[TEX_RAMP]) begin
        if (tex_ctrl[RAMP_DECAL]) begin
          tex_c.r = mix8(FRAG_IN.texel.r, FRAG_IN.color.r, FRAG_IN.texel.a); // [RL7]
          tex_c.g = mix8(FRAG_IN.texel.g, FRAG_IN.color.g, FRAG_IN.texel.a);
          tex_c.b = mix8(FRAG_IN.texel.b, FRAG_IN.color.b, FRAG_IN.texel.a);
        end else begin
          tex_c = FRAG_IN.texel; // [RL7]
          tex_c.a = mul8(FRAG_IN.texel.a, FRAG_IN.color.a);
        end
        if (tex_ctrl[RAMP_MOD]) begin // [RL6]
          tex_c.r = mul8(kd, tex_c.r); // [RL8]
          tex_c.g = mul8(kd, tex_c.g);
          tex_c.b = mul8(kd, tex_c.b);
          tex_c.a = mul8(kd, tex_c.a);
        end
        if (tex_ctrl[RAMP_HI]) begin // [RL6]
          tex_c.r = add8(tex_c.r, ks); // [RL9]
          tex_c.g = add8(tex_c.g, ks);
          tex_c.b = add8(tex_c.b, ks);
          tex_c.a = add8(tex_c.a, ks);
        end
      end else begin
        unique case (rgb_mode)
          RGB_DECAL: begin
            tex_c.r = mix8(FRAG_IN.texel.r, FRAG_IN.color.r, FRAG_IN.texel.a); // [RL4]
            tex_c.g = mix8(FRAG_IN.texel.g, FRAG_IN.color.g, FRAG_IN.texel.a);
            tex_c.b = mix8(FRAG_IN.texel.b, FRAG_IN.color.b, FRAG_IN.texel.a);
          end
          RGB_MODULATE: begin
            tex_c.r = mul8(FRAG_IN.texel.r, FRAG_IN.color.r); // [RL5]
            tex_c.g = mul8(FRAG_IN.texel.g, FRAG_IN.color.g);
            tex_c.b = mul8(FRAG_IN.texel.b, FRAG_IN.color.b);
            tex_c.a = mul8(FRAG_IN.texel.a, FRAG_IN.color.a);
          end
          default: tex_c = FRAG_IN.texel; // [RL3] copy, and the unused code
        endcase
      end
    end
  end

  // fog stage works on the textured colour
  always_comb begin
    fog_c = tex_c; // [RL1]
    reject = 1'b0;
    if (fog_ctrl[FOG_EN] && FRAG_IN.fog_apply) begin // [RL10]
      reject = fog_ctrl[FOG_TEST] && dda_val[0][FIX_W-1]; // [RL11]
      fog_c.r = mix8(tex_c.r, cfg[2][7:0], f); // [RL15]
      fog_c.g = mix8(tex_c.g, cfg[2][15:8], f);
      fog_c.b = mix8(tex_c.b, cfg[2][23:16], f);
    end
  end

  // destination unpack; the extension bit swaps red and blue
  always_comb begin
    logic sr;
    logic sa;
    logic [7:0] t;
    logic [31:0] p;
    sr = blend_ctrl[BL_RGB_SHIFT];
    sa = blend_ctrl[BL_A_SHIFT];
    t = 8'h00;
    p = FRAG_IN.dest_raw;
    unique case (tfb_layout_t'(blend_ctrl[BL_LAYOUT +: 3])) // [RL16]
      LAY_5551: dst_c = '{expand({7'h00, p[15]}, 1, sa), expand({3'h0, p[14:10]}, 5, sr),
                          expand({3'h0, p[9:5]}, 5, sr), expand({3'h0, p[4:0]}, 5, sr)};
      LAY_565: dst_c = '{UNITY, expand({3'h0, p[15:11]}, 5, sr),
                         expand({2'h0, p[10:5]}, 6, sr), expand({3'h0, p[4:0]}, 5, sr)};
      LAY_332: dst_c = '{UNITY, expand({6'h00, p[7:6]}, 2, sr),
                         expand({5'h00, p[5:3]}, 3, sr), expand({5'h00, p[2:0]}, 3, sr)};
      LAY_4444: dst_c = '{expand({4'h0, p[15:12]}, 4, sa), expand({4'h0, p[11:8]}, 4, sr),
                          expand({4'h0, p[7:4]}, 4, sr), expand({4'h0, p[3:0]}, 4, sr)};
      default: dst_c = p;
    endcase
    if (blend_ctrl[BL_EXT]) begin // [RL16]
      t = dst_c.r;
      dst_c.r = dst_c.b;
      dst_c.b = t;
    end
    if (blend_ctrl[BL_DA_ONE]) begin
      dst_c.a = UNITY; // [RL17]
    end
  end

  // blend stage, last in the chain
  always_comb begin
    result = fog_c; // [RL1]
    if (blend_ctrl[BL_EN]) begin
      unique case (blend_op)
        OP_BLEND: begin
          result.r = mix8(fog_c.r, dst_c.r, fog_c.a); // [RL18]
          result.g = mix8(fog_c.g, dst_c.g, fog_c.a);
          result.b = mix8(fog_c.b, dst_c.b, fog_c.a);
          result.a = mix8(fog_c.a, dst_c.a, fog_c.a);
        end
        OP_SOURCE_ADDED_MODE: begin
          result.r = add8(fog_c.r, mul8(dst_c.r, ~fog_c.a)); // [RL19]
          result.g = add8(fog_c.g, mul8(dst_c.g, ~fog_c.a));
          result.b = add8(fog_c.b, mul8(dst_c.b, ~fog_c.a));
          result.a = add8(fog_c.a, mul8(dst_c.a, ~fog_c.a));
        end
        default: result = dst_c; // [RL20] format only, no mixing
      endcase
    end
  end

  // -------
  // output stage with one skid slot
  // -------
  tfb_rgba_t skid_color;
  logic skid_valid;
  logic next_skid_valid;
  logic out_free;

  assign keep = take && !reject; // [RL24]
  assign out_free = !OUT_VALID || OUT_READY;
  // skid fills only when a result arrives against a stalled output
  assign next_skid_valid = skid_valid ? !out_free : (keep && !out_free);

  // registered ready keeps full rate without a combinational path
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      skid_valid <= 1'b0;
      skid_color <= '0;
      FRAG_READY <= 1'b1;
    end else begin
      skid_valid <= next_skid_valid;
      FRAG_READY <= !next_skid_valid; // [RL24]
      if (keep && !out_free) begin
        skid_color <= result;
      end
    end
  end

  // older skid entry leaves before any newer result
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      OUT_VALID <= 1'b0;
      OUT_COLOR <= '0;
    end else if (out_free) begin
      if (skid_valid) begin
        OUT_VALID <= 1'b1;
        OUT_COLOR <= skid_color; // [RL24]
      end else if (keep) begin
        OUT_VALID <= 1'b1;
        OUT_COLOR <= result;
      end else begin
        OUT_VALID <= 1'b0;
      end
    end
  end

  // counters of delivered and dropped fragments, wrap at 16 bits
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      out_count <= 16'h0000;
      rej_count <= 16'h0000;
    end else begin
      if (OUT_VALID && OUT_READY) begin
        out_count <= out_count + 16'h0001;
      end
      if (take && reject) begin
        rej_count <= rej_count + 16'h0001;
      end
    end
  end
endmodule : tfb_core
`default_nettype wire

// ### rtl/tfb_pkg.sv
package tfb_pkg;
  // -------
  // register byte offsets
  // -------
  localparam logic [7:0] A_TEX_CTRL = 8'h00;
  localparam logic [7:0] A_FOG_CTRL = 8'h04;
  localparam logic [7:0] A_FOG_COLOR = 8'h08;
  localparam logic [7:0] A_FOG_START = 8'h0C;
  localparam logic [7:0] A_FOG_SPAN = 8'h10;
  localparam logic [7:0] A_FOG_EDGE = 8'h14;
  localparam logic [7:0] A_SPEC_START = 8'h18;
  localparam logic [7:0] A_SPEC_SPAN = 8'h1C;
  localparam logic [7:0] A_SPEC_EDGE = 8'h20;
  localparam logic [7:0] A_DIFF_START = 8'h24;
  localparam logic [7:0] A_DIFF_SPAN = 8'h28;
  localparam logic [7:0] A_DIFF_EDGE = 8'h2C;
  localparam logic [7:0] A_BLEND_CTRL = 8'h30;
  localparam logic [7:0] A_STATUS = 8'h34;
  localparam int NUM_REGS = 14;
  localparam int IDX_STATUS = 13;
  // -------
  // field positions and masks
  // -------
  localparam int TEX_EN = 0;
  localparam int TEX_RAMP = 1;
  localparam int TEX_MODE = 2;
  localparam int RAMP_DECAL = 4;
  localparam int RAMP_MOD = 5;
  localparam int RAMP_HI = 6;
  localparam int SPEC_EN = 7;
  localparam int DIFF_EN = 8;
  localparam int FOG_EN = 0;
  localparam int FOG_TEST = 1;
  localparam int BL_EN = 0;
  localparam int BL_OP = 1;
  localparam int BL_LAYOUT = 3;
  localparam int BL_EXT = 6;
  localparam int BL_DA_ONE = 7;
  localparam int BL_RGB_SHIFT = 8;
  localparam int BL_A_SHIFT = 9;
  localparam logic [31:0] M_TEX = 32'h0000_01FF;
  localparam logic [31:0] M_FOG = 32'h0000_0003;
  localparam logic [31:0] M_FIX = 32'h0003_FFFF;
  localparam logic [31:0] M_BLEND = 32'h0000_03FF;
  localparam logic [31:0] M_WORD = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  localparam int FIX_W = 18;
  localparam logic [7:0] UNITY = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // -------
  // modes
  // -------
  typedef enum logic [1:0] {
    RGB_COPY = 2'b00,
    RGB_DECAL = 2'b01,
    RGB_MODULATE = 2'b10
  } tfb_rgb_mode_t;
  typedef enum logic [1:0] {
    OP_FORMAT = 2'b00,
    OP_BLEND = 2'b01,
    OP_SOURCE_ADDED_MODE = 2'b10
  } tfb_blend_op_t;
  typedef enum logic [2:0] {
    LAY_8888 = 3'b000,
    LAY_5551 = 3'b001,
    LAY_565 = 3'b010,
    LAY_332 = 3'b011,
    LAY_4444 = 3'b100
  } tfb_layout_t;
  // -------
  // carriers
  // -------
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] g;
    logic [7:0] r;
  } tfb_rgba_t;
  typedef struct packed {
    tfb_rgba_t color;
    tfb_rgba_t texel;
    logic [31:0] dest_raw;
    logic tex_apply;
    logic fog_apply;
    logic prim_first;
    logic row_first;
    logic is_line;
  } tfb_frag_t;
endpackage : tfb_pkg

// ### dv/tfb_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tfb_chk (
  input wire logic CLOCK, // core clock
  input wire logic RST_N, // reset, active low
  input wire logic AWVALID, // aw valid
  input wire logic AWREADY, // aw ready
  input wire logic WVALID, // w valid
  input wire logic WREADY, // w ready
  input wire logic BVALID, // b valid
  input wire logic BREADY, // b ready
  input wire logic ARVALID, // ar valid
  input wire logic ARREADY, // ar ready
  input wire logic RVALID, // r valid
  input wire logic RREADY, // r ready
  input wire logic FRAG_VALID, // fragment offered
  input wire logic FRAG_READY, // fragment taken
  input wire logic OUT_VALID, // result offered
  input wire logic OUT_READY, // result taken
  input wire tfb_pkg::tfb_rgba_t OUT_COLOR // result colour
);
  import tfb_pkg::*;
  // -------
  // stream and bus relations
  // -------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  AST_OUT_HOLD: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_COLOR))
    else $error("result dropped or changed while stalled");
  AST_OUT_IDLE: assert property (!OUT_VALID && !(FRAG_VALID && FRAG_READY) |=> !OUT_VALID)
    else $error("result appeared with no fragment taken");
  // back-pressure only once the output slot is occupied
  AST_STALL_READY: assert property (!FRAG_READY |-> OUT_VALID)
    else $error("input refused with free output");
  AST_B_LAT: assert property (AWVALID && AWREADY && WVALID && WREADY |=> ##1 BVALID)
    else $error("write response late");
  AST_B_DONE: assert property (BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
    else $error("write channel not freed after response");
  AST_R_LAT: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read data late");
  AST_R_DONE: assert property (RVALID && RREADY |=> !RVALID && ARREADY)
    else $error("read channel not freed after data");
  AST_W_BUSY: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write accepted while response pending");
endmodule : tfb_chk
bind tfb_core tfb_chk tfb_chk_inst (.CLOCK, .RST_N, .AWVALID, .AWREADY, .WVALID, .WREADY,
  .BVALID, .BREADY, .ARVALID, .ARREADY, .RVALID, .RREADY, .FRAG_VALID, .FRAG_READY,
  .OUT_VALID, .OUT_READY, .OUT_COLOR);
`default_nettype wire

// ### dv/tfb_src.sv
`timescale 1ns/1ps
`default_nettype none
module tfb_src (
  input wire logic clk, // core clock
  input wire logic rst_n, // reset, active low
  input wire logic ready, // stage can take
  output logic valid, // fragment offered
  output tfb_pkg::tfb_frag_t frag // fragment payload
);
  import tfb_pkg::*;
  tfb_frag_t q[$];
  int gap = 0;
  int idle = 0;
  initial valid = 1'h0;
  initial frag = '0;
  // offer held until taken; released payload inverts so stale data never passes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid <= 1'h0;
    end else if (valid && ready) begin
      if (gap == 0 && q.size() > 0) frag <= q.pop_front();
      else begin
        valid <= 1'h0;
        frag <= ~frag;
        idle <= gap;
      end
    end else if (!valid && idle > 0) begin
      idle <= idle - 1;
      frag <= ~frag;
    end else if (!valid && q.size() > 0) begin
      frag <= q.pop_front();
      valid <= 1'h1;
    end
  end
endmodule : tfb_src
`default_nettype wire

// ### dv/tfb_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tfb_core_tb;
  import tfb_pkg::*;
  logic CLOCK = 1'h0, RST_N = 1'h0, AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h1;
  logic ARVALID = 1'h0, RREADY = 1'h1, OUT_READY = 1'h1;
  logic [7:0] AWADDR = '0, ARADDR = '0;
  logic [31:0] WDATA = '0, RDATA, rv, m;
  logic [3:0] WSTRB = 4'hF;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, FRAG_VALID, FRAG_READY, OUT_VALID;
  logic [1:0] BRESP, RRESP, rr;
  tfb_frag_t FRAG_IN;
  tfb_rgba_t OUT_COLOR, o, e;
  tfb_rgba_t c = 32'h80C04020, t = 32'h40F03090, d = 32'h406080A0, fc = 32'h11223344;
  logic [31:0] fx [4] = '{32'h11, 32'h111, 32'h9, 32'h209};
  logic [31:0] fd [4] = '{32'h8010, 32'h8010, 32'h8000, 32'h8000};
  logic [31:0] fe [4] = '{32'hFF840084, 32'hFF800080, 32'hFF000000, 32'h80000000};
  int n_errors = 0, tests_run = 0;
  tfb_rgba_t got_q[$];
  tfb_core tfb_core_inst (.CLOCK, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
    .RREADY, .FRAG_VALID, .FRAG_READY, .FRAG_IN, .OUT_VALID, .OUT_READY, .OUT_COLOR);
  tfb_src tfb_src_inst (.clk(CLOCK), .rst_n(RST_N), .ready(FRAG_READY), .valid(FRAG_VALID),
    .frag(FRAG_IN));
  // -------
  // clock, result capture, watchdog
  // -------
  initial forever #12.5 CLOCK = ~CLOCK;
  // results queued in arrival order for the scenarios
  always @(posedge CLOCK) if (RST_N && OUT_VALID === 1'h1 && OUT_READY) got_q.push_back(OUT_COLOR);
  // whole run needs a few hundred cycles
  initial begin
    repeat (40000) @(posedge CLOCK);
    n_errors++;
    summarize();
  end
  // -------
  // reference arithmetic and helpers
  // -------
  function automatic logic [7:0] mul8(logic [7:0] x, logic [7:0] y);
    logic [16:0] p;
    p = x * y;
    return 8'((p + 17'h80 + (p >> 8)) >> 8);
  endfunction : mul8
  function automatic logic [7:0] add8(logic [7:0] x, logic [7:0] y);
    logic [8:0] s;
    s = x + y;
    return s[8] ? 8'hFF : s[7:0];
  endfunction : add8
  // per byte: 0 mix by k, 1 product, 2 saturating sum
  function automatic tfb_rgba_t cw(tfb_rgba_t x, tfb_rgba_t y, logic [7:0] k, int op);
    logic [7:0] a, b;
    for (int i = 0; i < 4; i++) begin
      a = x[i*8+:8];
      b = y[i*8+:8];
      cw[i*8+:8] = (op == 0) ? add8(mul8(a, k), mul8(b, ~k)) : (op == 1) ? mul8(a, b) : add8(a, b);
    end
  endfunction : cw
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    AWADDR <= a;
    WDATA <= dt;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    do begin
      @(posedge CLOCK);
      if (AWREADY) AWVALID <= 1'h0;
      if (WREADY) WVALID <= 1'h0;
    end while (BVALID !== 1'h1);
    rr = BRESP;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    ARADDR <= a;
    ARVALID <= 1'h1;
    do begin
      @(posedge CLOCK);
      if (ARREADY) ARVALID <= 1'h0;
    end while (RVALID !== 1'h1);
    rv = RDATA;
    rr = RRESP;
  endtask : rd
  task automatic take();
    while (got_q.size() == 0) @(posedge CLOCK);
    o = got_q.pop_front();
  endtask : take
  task automatic run(input tfb_rgba_t col, input logic [31:0] dr, input logic [4:0] fl);
    tfb_src_inst.q.push_back({col, t, dr, fl});
    take();
  endtask : run
  task summarize();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // -------
  // scenarios
  // -------
  initial begin
    repeat (5) @(posedge CLOCK);
    RST_N <= 1'h1;
    @(posedge CLOCK);
    for (int i = 0; i < 13; i++) begin
      m = (i == 0) ? M_TEX : (i == 1) ? M_FOG : (i == 2) ? M_WORD : (i == 12) ? M_BLEND : M_FIX;
      rd(8'(i * 4));
      chk("reset value", rv, RST_VAL);
      wr(8'(i * 4), M_WORD);
      rd(8'(i * 4));
      chk("writable bits", rv, m);
      wr(8'(i * 4), RST_VAL);
    end
    wr(A_STATUS, M_WORD);
    chk("status write", {30'h0, rr}, {30'h0, RESP_OKAY});
    wr(8'h38, M_WORD);
    chk("unmapped write", {30'h0, rr}, {30'h0, RESP_SLVERR});
    rd(A_STATUS);
    chk("status", rv, RST_VAL);
    rd(8'h38);
    chk("unmapped", {30'h0, rr}, {30'h0, RESP_SLVERR});
    $display("test registers done");
    wr(A_TEX_CTRL, 32'h1);
    run(c, '0, 5'h14);
    chk("copy", {8'h0, o[23:0]}, {8'h0, t[23:0]});
    run(c, '0, 5'h04);
    chk("no tex flag", o, c);
    wr(A_TEX_CTRL, 32'h5);
    run(c, '0, 5'h14);
    e = cw(t, c, t.a, 0);
    e.a = c.a;
    chk("decal", o, e);
    wr(A_TEX_CTRL, 32'h9);
    run(c, '0, 5'h14);
    chk("modulate", o, cw(t, c, 0, 1));
    wr(A_DIFF_START, 32'h8000);
    wr(A_SPEC_START, 32'h1000);
    wr(A_TEX_CTRL, 32'h1F3);
    run(c, '0, 5'h14);
    e = cw(t, c, t.a, 0);
    e.a = c.a;
    chk("ramp", o, cw(cw(e, {4{8'h80}}, 0, 1), {4{8'h10}}, 0, 2));
    wr(A_TEX_CTRL, 32'h1E3);
    run(c, '0, 5'h14);
    e = t;
    e.a = mul8(t.a, c.a);
    chk("ramp no decal", o, cw(cw(e, {4{8'h80}}, 0, 1), {4{8'h10}}, 0, 2));
    wr(A_TEX_CTRL, RST_VAL);
    $display("test texture done");
    tfb_src_inst.gap = 3;
    wr(A_FOG_COLOR, fc);
    wr(A_FOG_START, 32'h8000);
    wr(A_FOG_SPAN, 32'h4000);
    wr(A_FOG_EDGE, 32'h10000);
    wr(A_FOG_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      run(c, '0, (i == 0) ? 5'h0C : (i == 1) ? 5'h08 : 5'h0A);
      e = cw(c, fc, (i == 0) ? 8'h80 : (i == 1) ? 8'hC0 : 8'hFF, 0);
      e.a = c.a;
      chk("fog index", o, e);
    end
    run(c, '0, 5'h00);
    chk("no fog flag", o, c);
    wr(A_FOG_START, 32'h38000);
    wr(A_FOG_CTRL, 32'h3);
    tfb_src_inst.q.push_back({c, t, 32'h0, 5'h0C});
    repeat (10) @(posedge CLOCK);
    chk("rejected", 32'(got_q.size()), '0);
    rd(A_STATUS);
    chk("reject count", {16'h0, rv[31:16]}, 32'h1);
    wr(A_FOG_CTRL, 32'h1);
    run(c, '0, 5'h0C);
    e = cw(c, fc, 8'h00, 0);
    e.a = c.a;
    chk("fog clamp low", o, e);
    wr(A_FOG_CTRL, RST_VAL);
    tfb_src_inst.gap = 0;
    $display("test fog done");
    wr(A_BLEND_CTRL, 32'h3);
    run(c, d, 5'h04);
    chk("blend", o, cw(c, d, c.a, 0));
    wr(A_BLEND_CTRL, 32'h83);
    run(c, d, 5'h04);
    chk("dest alpha one", o, cw(c, {8'hFF, d[23:0]}, c.a, 0));
    wr(A_BLEND_CTRL, 32'h5);
    run(c, d, 5'h04);
    chk("source_added_mode", o, cw(c, cw(d, {4{~c.a}}, 0, 1), 0, 2));
    for (int i = 0; i < 4; i++) begin
      wr(A_BLEND_CTRL, fx[i]);
      run(c, fd[i], 5'h04);
      chk("format", o, fe[i]);
    end
    wr(A_BLEND_CTRL, RST_VAL);
    $display("test blend done");
    OUT_READY <= 1'h0;
    for (int i = 0; i < 3; i++) tfb_src_inst.q.push_back({c[31:8], 8'(i), t, 32'h0, 5'h04});
    repeat (8) @(posedge CLOCK);
    chk("stall ready", {31'h0, FRAG_READY}, '0);
    OUT_READY <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      take();
      chk("order", o, {c[31:8], 8'(i)});
    end
    $display("test stream done");
    summarize();
  end
endmodule : tfb_core_tb
`default_nettype wire
